/* File: hw/presence_pwm_map.svh */
`ifndef PRESENCE_PWM_MAP_SVH
`define PRESENCE_PWM_MAP_SVH

// pin selector that names the presence output
`define SEL_PRESENCE 8'h01
// polarity value field in the polarity argument
`define POL_BIT 0
`define POL_LIMIT 8'h01
`define POL_DEFAULT 1'b1

// duty limits and reset profile
`define DUTY_LIMIT 8'h64
`define DUTY_FULL 7'h64
`define IDLE_DUTY_DEFAULT 7'h00
`define DET_DUTY_DEFAULT 7'h64
`define RAMP_LEN_DEFAULT 8'h00

// words carried by each reply
`define REPLY_WORDS_NONE 2'h0
`define REPLY_WORDS_POL 2'h2
`define REPLY_WORDS_DUTY 2'h3

// timing
`define RAMP_STEP_TIME_MS 64
`define CLK_FREQ_KHZ 100000
`define PWM_SLOTS 7'h64
`define PWM_PRESCALE_DEF 10

`endif

/* File: hw/presence_pwm_pkg.sv */
package presence_pwm_pkg;

   typedef enum logic [3:0] {
      CMD_SET_POL  = 4'h1,
      CMD_GET_POL  = 4'h2,
      CMD_SET_DUTY = 4'h4,
      CMD_GET_DUTY = 4'h8
   } cmd_op_e;

   typedef enum logic [2:0] {
      RAMP_HOLD = 3'h1,
      RAMP_UP   = 3'h2,
      RAMP_DOWN = 3'h4
   } ramp_state_e;

   typedef logic [7:0] arg_t;
   typedef logic [6:0] duty_t;

endpackage

/* File: hw/duty_link_if.sv */
interface duty_link_if;
   import presence_pwm_pkg::*;
   logic ce;
   logic step_tick;
   logic detect;
   logic polarity;
   duty_t idle_duty;
   duty_t det_duty;
   arg_t ramp_len;
   duty_t duty;
   logic ramping;

   modport ctl(output ce, step_tick, detect, polarity, idle_duty, det_duty, ramp_len,
      input duty, ramping);
   modport ramp(input ce, step_tick, detect, idle_duty, det_duty, ramp_len,
      output duty, ramping);
   modport stage(input ce, duty, polarity);
endinterface

/* File: hw/duty_ramp.sv */
`include "presence_pwm_map.svh"

module duty_ramp
   import presence_pwm_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // link to control and output stage
   duty_link_if.ramp link
);

   ramp_state_e state_ff;
   ramp_state_e nxt_state;
   arg_t pos_ff;
   duty_t duty_ff;
   duty_t nxt_duty;
   logic rising;
   duty_t span;
   logic [14:0] prod;
   logic [14:0] quo;

   always_comb begin
      if (link.ramp_len == 8'h00) begin
         nxt_state = RAMP_HOLD;
      end else if (link.detect && pos_ff < link.ramp_len) begin
         nxt_state = RAMP_UP;
      end else if (!link.detect && pos_ff != 8'h00) begin
         nxt_state = RAMP_DOWN;
      end else begin
         nxt_state = RAMP_HOLD;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_ff <= RAMP_HOLD;
      end else if (link.ce) begin
         state_ff <= nxt_state;
      end
   end

   // position counts 64 ms steps from the idle end toward the detected end
   always_ff @(posedge mclk) begin
      if (rst) begin
         pos_ff <= 8'h00;
      end else if (link.ce) begin
         if (link.ramp_len == 8'h00) begin
            pos_ff <= 8'h00;
         end else if (pos_ff > link.ramp_len) begin
            pos_ff <= link.ramp_len;
         end else if (link.step_tick) begin
            case (state_ff)
               RAMP_UP: if (pos_ff < link.ramp_len) pos_ff <= pos_ff + 8'h01;
               RAMP_DOWN: if (pos_ff != 8'h00) pos_ff <= pos_ff - 8'h01;
               RAMP_HOLD: pos_ff <= pos_ff;
               default: pos_ff <= pos_ff;
            endcase
         end
      end
   end

   // linear interpolation between the two levels
   always_comb begin
      rising = link.det_duty >= link.idle_duty;
      span = rising ? link.det_duty - link.idle_duty : link.idle_duty - link.det_duty;
      prod = {8'h00, span} * {7'h00, pos_ff};
      quo = (link.ramp_len == 8'h00) ? 15'h0000 : prod / {7'h00, link.ramp_len};
      if (link.ramp_len == 8'h00) begin
         nxt_duty = link.detect ? link.det_duty : link.idle_duty;
      end else if (rising) begin
         nxt_duty = link.idle_duty + quo[6:0];
      end else begin
         nxt_duty = link.idle_duty - quo[6:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         duty_ff <= `IDLE_DUTY_DEFAULT;
      end else if (link.ce) begin
         duty_ff <= nxt_duty;
      end
   end

   assign link.duty = duty_ff;
   assign link.ramping = state_ff != RAMP_HOLD;

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   property p_zero_ramp_direct;
      (link.ce && link.ramp_len == 8'h00 && link.detect) |=> duty_ff == $past(link.det_duty);
   endproperty
   a_zero_ramp_direct: assert property (p_zero_ramp_direct) else $error("no jump at zero ramp");

   property p_step_on_tick;
      (pos_ff != $past(pos_ff) && $past(link.ramp_len) != 8'h00
         && $past(pos_ff) <= $past(link.ramp_len)) |-> $past(link.step_tick);
   endproperty
   a_step_on_tick: assert property (p_step_on_tick) else $error("ramp moved off tick");

endmodule

/* File: hw/pwm_stage.sv */
`include "presence_pwm_map.svh"

module pwm_stage
   import presence_pwm_pkg::*;
#(
   parameter int PRESCALE = `PWM_PRESCALE_DEF
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // duty and polarity
   duty_link_if.stage link,
   // presence pin
   output logic presence_out
);

   localparam int PW = $clog2(PRESCALE + 1);

   logic [PW-1:0] pre_ff;
   duty_t slot_ff;
   duty_t duty_lat_ff;
   logic pol_lat_ff;
   logic out_ff;
   logic slot_end;
   logic wrap;
   logic raw;

   assign slot_end = pre_ff == PW'(PRESCALE - 1);
   assign wrap = slot_end && slot_ff == `PWM_SLOTS - 7'h01;

   always_ff @(posedge mclk) begin
      if (rst) begin
         pre_ff <= '0;
         slot_ff <= 7'h00;
      end else if (link.ce) begin
         pre_ff <= slot_end ? '0 : pre_ff + PW'(1);
         if (slot_end) begin
            slot_ff <= wrap ? 7'h00 : slot_ff + 7'h01;
         end
      end
   end

   // new duty and polarity only at the period edge, so no runt pulse appears
   always_ff @(posedge mclk) begin
      if (rst) begin
         duty_lat_ff <= `IDLE_DUTY_DEFAULT;
         pol_lat_ff <= `POL_DEFAULT;
      end else if (link.ce && wrap) begin
         duty_lat_ff <= link.duty;
         pol_lat_ff <= link.polarity;
      end
   end

   // slot below duty is high, so 100 is always high and 0 always low
   assign raw = slot_ff < duty_lat_ff;

   always_ff @(posedge mclk) begin
      if (rst) begin
         out_ff <= 1'b0;
      end else if (link.ce) begin
         out_ff <= pol_lat_ff ? raw : ~raw;
      end
   end

   assign presence_out = out_ff;

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   property p_full_duty_level;
      (link.ce && duty_lat_ff == `DUTY_FULL) |=> out_ff == $past(pol_lat_ff);
   endproperty
   a_full_duty_level: assert property (p_full_duty_level) else $error("full duty level wrong");

   property p_zero_duty_level;
      (link.ce && duty_lat_ff == 7'h00) |=> out_ff == !$past(pol_lat_ff);
   endproperty
   a_zero_duty_level: assert property (p_zero_duty_level) else $error("zero duty level wrong");

   property p_latch_at_edge;
      (duty_lat_ff != $past(duty_lat_ff)) |-> $past(wrap) && $past(link.ce);
   endproperty
   a_latch_at_edge: assert property (p_latch_at_edge) else $error("duty changed mid period");

endmodule

/* File: hw/presence_output_pwm.sv */
// Notes on behaviour
// - With polarity 0 the presence pin is low while a target is seen and high otherwise.
// - With polarity 1, the reset default, the pin is high on a target and low otherwise.
// - The polarity command names pin selector 1 for the presence pin, then the value.
// - A polarity read returns the selector and that pin's current polarity.
// - The pin carries a PWM wave where, with polarity 1, 100 percent is steady high and 0 percent steady low.
// - The first duty value, 0 to 100, is the duty used with no target present.
// - The second duty value, 0 to 100, is the duty used while a target is present.
// - The third duty value, 0 to 255, makes the ramp between the levels last that many 64 ms.
// - Polarity is applied in the PWM output stage and decides which level is active.
// - The PWM wave leaves on the presence pin itself, not a separate pin.
// - A duty read returns idle duty, detected duty and ramp step count in that order.
// - Each configuration command answers success when applied and failure when rejected.
`include "presence_pwm_map.svh"

module presence_output_pwm
   import presence_pwm_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = `RAMP_STEP_TIME_MS * `CLK_FREQ_KHZ,
   parameter int PWM_PRESCALE = `PWM_PRESCALE_DEF
)
(
   // clock, reset and enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // detection result from radar processing
   input wire logic target_detected,
   // command port
   input wire logic cmd_valid,
   input wire cmd_op_e cmd_op,
   input wire arg_t cmd_arg0,
   input wire arg_t cmd_arg1,
   input wire arg_t cmd_arg2,
   input wire logic cmd_arg2_given,
   // reply port
   output logic rsp_valid,
   output logic rsp_ok,
   output logic [1:0] rsp_count,
   output arg_t rsp_word0,
   output arg_t rsp_word1,
   output arg_t rsp_word2,
   // status
   output duty_t duty_now,
   output logic polarity_now,
   output logic ramp_active,
   // presence pin
   output logic presence_out
);

   localparam int TW = $clog2(STEP_CYCLES + 1);

   duty_link_if link();

   // configuration
   logic pol_ff;
   duty_t idle_ff;
   duty_t det_ff;
   arg_t ramp_ff;
   logic nxt_pol;
   duty_t nxt_idle;
   duty_t nxt_det;
   arg_t nxt_ramp;

   // reply
   logic rsp_valid_ff;
   logic rsp_ok_ff;
   logic [1:0] rsp_count_ff;
   arg_t rsp_w0_ff;
   arg_t rsp_w1_ff;
   arg_t rsp_w2_ff;
   logic nxt_ok;
   logic [1:0] nxt_count;
   arg_t nxt_w0;
   arg_t nxt_w1;
   arg_t nxt_w2;

   // ramp step timer
   logic [TW-1:0] tmr_ff;
   logic step_tick;

   logic take;
   logic sel_ok;
   logic pol_val_ok;
   logic duty_args_ok;

   assign take = ce && cmd_valid;
   assign sel_ok = cmd_arg0 == `SEL_PRESENCE;
   assign pol_val_ok = cmd_arg1 <= `POL_LIMIT;
   assign duty_args_ok = cmd_arg0 <= `DUTY_LIMIT && cmd_arg1 <= `DUTY_LIMIT;

   // decode: rejected commands leave every setting untouched
   always_comb begin
      nxt_pol = pol_ff;
      nxt_idle = idle_ff;
      nxt_det = det_ff;
      nxt_ramp = ramp_ff;
      nxt_ok = 1'b0;
      nxt_count = `REPLY_WORDS_NONE;
      nxt_w0 = 8'h00;
      nxt_w1 = 8'h00;
      nxt_w2 = 8'h00;
      case (cmd_op)
         CMD_SET_POL: begin
            if (sel_ok && pol_val_ok) begin
               nxt_pol = cmd_arg1[`POL_BIT];
               nxt_ok = 1'b1;
            end
         end
         CMD_GET_POL: begin
            if (sel_ok) begin
               nxt_ok = 1'b1;
               nxt_count = `REPLY_WORDS_POL;
               nxt_w0 = cmd_arg0;
               nxt_w1 = {7'h00, pol_ff};
            end
         end
         CMD_SET_DUTY: begin
            if (duty_args_ok) begin
               nxt_idle = cmd_arg0[6:0];
               nxt_det = cmd_arg1[6:0];
               nxt_ramp = cmd_arg2_given ? cmd_arg2 : 8'h00;
               nxt_ok = 1'b1;
            end
         end
         CMD_GET_DUTY: begin
            nxt_ok = 1'b1;
            nxt_count = `REPLY_WORDS_DUTY;
            nxt_w0 = {1'b0, idle_ff};
            nxt_w1 = {1'b0, det_ff};
            nxt_w2 = ramp_ff;
         end
         default: begin
            nxt_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pol_ff <= `POL_DEFAULT;
         idle_ff <= `IDLE_DUTY_DEFAULT;
         det_ff <= `DET_DUTY_DEFAULT;
         ramp_ff <= `RAMP_LEN_DEFAULT;
      end else if (take) begin
         pol_ff <= nxt_pol;
         idle_ff <= nxt_idle;
         det_ff <= nxt_det;
         ramp_ff <= nxt_ramp;
      end
   end

   // reply follows every taken command by one cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         rsp_valid_ff <= 1'b0;
      end else if (ce) begin
         rsp_valid_ff <= cmd_valid;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rsp_ok_ff <= 1'b0;
         rsp_count_ff <= `REPLY_WORDS_NONE;
         rsp_w0_ff <= 8'h00;
         rsp_w1_ff <= 8'h00;
         rsp_w2_ff <= 8'h00;
      end else if (take) begin
         rsp_ok_ff <= nxt_ok;
         rsp_count_ff <= nxt_count;
         rsp_w0_ff <= nxt_w0;
         rsp_w1_ff <= nxt_w1;
         rsp_w2_ff <= nxt_w2;
      end
   end

   // timer idles at zero between ramps so the first step is a full 64 ms
   assign step_tick = link.ramping && tmr_ff == TW'(STEP_CYCLES - 1);

   always_ff @(posedge mclk) begin
      if (rst) begin
         tmr_ff <= '0;
      end else if (ce) begin
         if (!link.ramping || step_tick) begin
            tmr_ff <= '0;
         end else begin
            tmr_ff <= tmr_ff + TW'(1);
         end
      end
   end

   assign link.ce = ce;
   assign link.step_tick = step_tick;
   assign link.detect = target_detected;
   assign link.polarity = pol_ff;
   assign link.idle_duty = idle_ff;
   assign link.det_duty = det_ff;
   assign link.ramp_len = ramp_ff;

   duty_ramp u_ramp (
      .mclk(mclk),
      .rst(rst),
      .link(link.ramp)
   );

   pwm_stage #(
      .PRESCALE(PWM_PRESCALE)
   ) u_stage (
      .mclk(mclk),
      .rst(rst),
      .link(link.stage),
      .presence_out(presence_out)
   );

   assign rsp_valid = rsp_valid_ff;
   assign rsp_ok = rsp_ok_ff;
   assign rsp_count = rsp_count_ff;
   assign rsp_word0 = rsp_w0_ff;
   assign rsp_word1 = rsp_w1_ff;
   assign rsp_word2 = rsp_w2_ff;
   assign duty_now = link.duty;
   assign polarity_now = pol_ff;
   assign ramp_active = link.ramping;

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_set_pol_good;
      take && cmd_op == CMD_SET_POL && sel_ok && pol_val_ok;
   endsequence

   sequence s_reply_ok;
      rsp_valid && rsp_ok;
   endsequence

   sequence s_reply_fail;
      rsp_valid && !rsp_ok;
   endsequence

   property p_set_pol_applies;
      s_set_pol_good |=> s_reply_ok and (pol_ff == $past(cmd_arg1[0]));
   endproperty
   a_set_pol_applies: assert property (p_set_pol_applies) else $error("polarity not set");

   property p_bad_selector;
      (take && cmd_op == CMD_SET_POL && !sel_ok) |=> s_reply_fail and $stable(pol_ff);
   endproperty
   a_bad_selector: assert property (p_bad_selector) else $error("bad selector accepted");

   property p_get_pol_reply;
      (take && cmd_op == CMD_GET_POL && sel_ok)
         |=> s_reply_ok and (rsp_word0 == `SEL_PRESENCE && rsp_word1 == {7'h00, pol_ff});
   endproperty
   a_get_pol_reply: assert property (p_get_pol_reply) else $error("polarity read wrong");

   property p_duty_range;
      (take && cmd_op == CMD_SET_DUTY && (cmd_arg0 > `DUTY_LIMIT || cmd_arg1 > `DUTY_LIMIT))
         |=> s_reply_fail and $stable(idle_ff) and $stable(det_ff) and $stable(ramp_ff);
   endproperty
   a_duty_range: assert property (p_duty_range) else $error("out of range duty taken");

   property p_set_duty_applies;
      (take && cmd_op == CMD_SET_DUTY && duty_args_ok)
         |=> s_reply_ok and (det_ff == $past(cmd_arg1[6:0]) && idle_ff == $past(cmd_arg0[6:0]));
   endproperty
   a_set_duty_applies: assert property (p_set_duty_applies) else $error("duty not set");

   property p_duty_reply;
      (take && cmd_op == CMD_GET_DUTY) |=> s_reply_ok
         and (rsp_word0 == {1'b0, idle_ff} && rsp_word1 == {1'b0, det_ff}
         && rsp_word2 == ramp_ff && rsp_count == `REPLY_WORDS_DUTY);
   endproperty
   a_duty_reply: assert property (p_duty_reply) else $error("duty read wrong");

   property p_one_reply;
      (ce && cmd_valid) |=> rsp_valid;
   endproperty
   a_one_reply: assert property (p_one_reply) else $error("command left unanswered");

   property p_no_stray_reply;
      (ce && !cmd_valid) |=> !rsp_valid;
   endproperty
   a_no_stray_reply: assert property (p_no_stray_reply) else $error("reply without command");

   property p_no_tick_zero_ramp;
      (ramp_ff == 8'h00 && $past(ramp_ff) == 8'h00) |-> !link.ramping ##1 !step_tick;
   endproperty
   a_no_tick_zero_ramp: assert property (p_no_tick_zero_ramp) else $error("ramp at zero length");

   property p_tick_spacing;
      step_tick |-> tmr_ff == TW'(STEP_CYCLES - 1) ##1 (tmr_ff == '0 || !$past(ce));
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("step timer off");

   property p_freeze;
      !ce |=> $stable(pol_ff) and $stable(tmr_ff) and $stable(rsp_valid) and $stable(duty_now);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while disabled");

   property p_reset_polarity;
      $fell(rst) |-> (pol_ff == 1'b1) [*2];
   endproperty
   a_reset_polarity: assert property (p_reset_polarity) else $error("reset polarity wrong");

endmodule

/* File: bench/host_model.sv */
module host_model
   import presence_pwm_pkg::*;
(
   // clock
   input wire logic mclk,
   // command side
   output logic cmd_valid,
   output cmd_op_e cmd_op,
   output arg_t cmd_arg0,
   output arg_t cmd_arg1,
   output arg_t cmd_arg2,
   output logic cmd_arg2_given,
   // reply side
   input wire logic rsp_valid,
   input wire logic rsp_ok,
   input wire logic [1:0] rsp_count,
   input wire arg_t rsp_word0,
   input wire arg_t rsp_word1,
   input wire arg_t rsp_word2
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cmd_valid = 1'b0;
      cmd_op = CMD_GET_POL;
      cmd_arg0 = 8'h00;
      cmd_arg1 = 8'h00;
      cmd_arg2 = 8'h00;
      cmd_arg2_given = 1'b0;
   end

   // selector and duty ranges are the caller's to keep; refusal tests break them on purpose
   task automatic send(input cmd_op_e op, input arg_t a0, input arg_t a1, input arg_t a2,
      input logic given, output logic v, output logic ok, output logic [1:0] cnt,
      output arg_t w0, output arg_t w1, output arg_t w2);
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_arg0 = a0;
      cmd_arg1 = a1;
      cmd_arg2 = a2;
      cmd_arg2_given = given;
      @(negedge mclk);
      v = rsp_valid;
      ok = rsp_ok;
      cnt = rsp_count;
      w0 = rsp_word0;
      w1 = rsp_word1;
      w2 = rsp_word2;
      // released arguments do not keep their old value
      cmd_valid = 1'b0;
      cmd_arg0 = ~cmd_arg0;
      cmd_arg1 = ~cmd_arg1;
      cmd_arg2 = ~cmd_arg2;
      cmd_arg2_given = ~cmd_arg2_given;
   endtask
endmodule

/* File: bench/testbench.sv */
module testbench
   import presence_pwm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int STEP = 20;
   localparam int PRE = 2;
   localparam int PERIOD = 100 * PRE;

   logic mclk, rst, ce, target_detected;
   logic cmd_valid, cmd_arg2_given, rsp_valid, rsp_ok, polarity_now, ramp_active, presence_out;
   cmd_op_e cmd_op;
   arg_t cmd_arg0, cmd_arg1, cmd_arg2, rsp_word0, rsp_word1, rsp_word2;
   logic [1:0] rsp_count;
   duty_t duty_now;
   int miscompares, n_checks;

   presence_output_pwm #(.STEP_CYCLES(STEP), .PWM_PRESCALE(PRE)) u_presence_output_pwm (
      .mclk(mclk), .rst(rst), .ce(ce), .target_detected(target_detected),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg0(cmd_arg0), .cmd_arg1(cmd_arg1),
      .cmd_arg2(cmd_arg2), .cmd_arg2_given(cmd_arg2_given), .rsp_valid(rsp_valid),
      .rsp_ok(rsp_ok), .rsp_count(rsp_count), .rsp_word0(rsp_word0), .rsp_word1(rsp_word1),
      .rsp_word2(rsp_word2), .duty_now(duty_now), .polarity_now(polarity_now),
      .ramp_active(ramp_active), .presence_out(presence_out));

   host_model u_host_model (
      .mclk(mclk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg0(cmd_arg0),
      .cmd_arg1(cmd_arg1), .cmd_arg2(cmd_arg2), .cmd_arg2_given(cmd_arg2_given),
      .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_count(rsp_count),
      .rsp_word0(rsp_word0), .rsp_word1(rsp_word1), .rsp_word2(rsp_word2));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      if (miscompares == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // every command is judged on marker, status, word count and all three words
   task automatic cmd(input cmd_op_e op, input arg_t a0, input arg_t a1, input arg_t a2,
      input logic given, input logic eok, input logic [1:0] ecnt,
      input arg_t e0, input arg_t e1, input arg_t e2);
      logic v, ok;
      logic [1:0] cnt;
      arg_t w0, w1, w2;
      u_host_model.send(op, a0, a1, a2, given, v, ok, cnt, w0, w1, w2);
      check("rsp_valid", 32'(v), 32'h1);
      check("rsp_ok", 32'(ok), 32'(eok));
      check("rsp_count", 32'(cnt), 32'(ecnt));
      check("rsp_word0", 32'(w0), 32'(e0));
      check("rsp_word1", 32'(w1), 32'(e1));
      check("rsp_word2", 32'(w2), 32'(e2));
   endtask

   // long enough for a duty change to reach a period boundary and show a full period
   task automatic settle();
      repeat (2 * PERIOD + 2) @(negedge mclk);
   endtask

   task automatic high_count(output int n);
      n = 0;
      repeat (PERIOD) begin
         @(negedge mclk);
         if (presence_out === 1'b1) n++;
      end
   endtask

   task automatic ramp_time(input duty_t goal, output int n, output logic seen_ramp);
      n = 0;
      seen_ramp = 1'b0;
      while (duty_now !== goal && n < 4 * PERIOD) begin
         @(negedge mclk);
         n++;
         if (ramp_active === 1'b1) seen_ramp = 1'b1;
      end
   endtask

   cmd_op_e bad_op[6] = '{CMD_SET_POL, CMD_SET_POL, CMD_GET_POL, CMD_SET_DUTY, CMD_SET_DUTY,
      cmd_op_e'(4'h3)};
   arg_t bad_a0[6] = '{8'h02, 8'h01, 8'h00, 8'h65, 8'h32, 8'h01};
   arg_t bad_a1[6] = '{8'h01, 8'h02, 8'h00, 8'h32, 8'h65, 8'h01};
   arg_t idle_tab[2] = '{8'h00, 8'h0A};
   arg_t det_tab[2] = '{8'h64, 8'h32};

   initial begin
      int n, d, exp_n;
      logic sr;
      logic v, ok;
      logic [1:0] cnt;
      arg_t w0, w1, w2;
      rst = 1'b1;
      ce = 1'b1;
      target_detected = 1'b0;
      miscompares = 0;
      n_checks = 0;
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      check("polarity_now", 32'(polarity_now), 32'h1);
      check("duty_now", 32'(duty_now), 32'h0);
      check("presence_out", 32'(presence_out), 32'h0);
      check("rsp_valid", 32'(rsp_valid), 32'h0);
      cmd(CMD_GET_DUTY, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1, 2'h3, 8'h00, 8'h64, 8'h00);
      cmd(CMD_GET_POL, 8'h01, 8'h00, 8'h00, 1'b0, 1'b1, 2'h2, 8'h01, 8'h01, 8'h00);
      for (int i = 0; i < 6; i++) begin
         cmd(bad_op[i], bad_a0[i], bad_a1[i], 8'h00, 1'b1, 1'b0, 2'h0, 8'h00, 8'h00,
            8'h00);
      end
      cmd(CMD_GET_DUTY, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1, 2'h3, 8'h00, 8'h64, 8'h00);
      for (int p = 1; p >= 0; p--) begin
         cmd(CMD_SET_POL, 8'h01, 8'(p), 8'h00, 1'b0, 1'b1, 2'h0, 8'h00, 8'h00, 8'h00);
         cmd(CMD_GET_POL, 8'h01, 8'h00, 8'h00, 1'b0, 1'b1, 2'h2, 8'h01, 8'(p), 8'h00);
         for (int k = 0; k < 2; k++) begin
            // ramp value present but not flagged as given, so no ramp
            cmd(CMD_SET_DUTY, idle_tab[k], det_tab[k], 8'h1F, 1'b0, 1'b1, 2'h0, 8'h00, 8'h00,
               8'h00);
            cmd(CMD_GET_DUTY, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1, 2'h3, idle_tab[k], det_tab[k],
               8'h00);
            for (int t = 0; t < 2; t++) begin
               target_detected = t[0];
               settle();
               d = t ? int'(det_tab[k]) : int'(idle_tab[k]);
               exp_n = p ? d * PRE : PERIOD - d * PRE;
               check("duty_now", 32'(duty_now), 32'(d));
               check("polarity_now", 32'(polarity_now), 32'(p));
               high_count(n);
               check("presence_high_cycles", 32'(n), 32'(exp_n));
            end
            target_detected = 1'b0;
         end
      end
      cmd(CMD_SET_POL, 8'h01, 8'h01, 8'h00, 1'b0, 1'b1, 2'h0, 8'h00, 8'h00, 8'h00);
      cmd(CMD_SET_DUTY, 8'h00, 8'h64, 8'h04, 1'b1, 1'b1, 2'h0, 8'h00, 8'h00, 8'h00);
      cmd(CMD_GET_DUTY, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1, 2'h3, 8'h00, 8'h64, 8'h04);
      settle();
      target_detected = 1'b1;
      ramp_time(7'h64, n, sr);
      check("ramp_active", 32'(sr), 32'h1);
      check("ramp_up_in_window", 32'(n >= 4 * STEP && n <= 4 * STEP + 3), 32'h1);
      target_detected = 1'b0;
      ramp_time(7'h00, n, sr);
      check("ramp_down_in_window", 32'(n >= 4 * STEP && n <= 4 * STEP + 3), 32'h1);
      settle();
      high_count(n);
      check("presence_high_cycles", 32'(n), 32'h0);
      // a low enable must freeze the ramp one step in and drop the command unanswered
      target_detected = 1'b1;
      repeat (STEP + 10) @(negedge mclk);
      ce = 1'b0;
      u_host_model.send(CMD_SET_POL, 8'h01, 8'h00, 8'h00, 1'b0, v, ok, cnt, w0, w1, w2);
      check("rsp_valid", 32'(v), 32'h0);
      repeat (3 * STEP) @(negedge mclk);
      check("duty_now", 32'(duty_now), 32'h19);
      check("ramp_active", 32'(ramp_active), 32'h1);
      ce = 1'b1;
      ramp_time(7'h64, n, sr);
      check("ramp_up_in_window", 32'(n >= 3 * STEP - 10 && n <= 3 * STEP - 7), 32'h1);
      cmd(CMD_GET_POL, 8'h01, 8'h00, 8'h00, 1'b0, 1'b1, 2'h2, 8'h01, 8'h01, 8'h00);
      cmd(CMD_SET_POL, 8'h01, 8'h00, 8'h00, 1'b0, 1'b1, 2'h0, 8'h00, 8'h00, 8'h00);
      // a second reset in mid-run must bring every default back
      target_detected = 1'b0;
      rst = 1'b1;
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      check("polarity_now", 32'(polarity_now), 32'h1);
      check("duty_now", 32'(duty_now), 32'h0);
      check("presence_out", 32'(presence_out), 32'h0);
      cmd(CMD_GET_DUTY, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1, 2'h3, 8'h00, 8'h64, 8'h00);
      cmd(CMD_GET_POL, 8'h01, 8'h00, 8'h00, 1'b0, 1'b1, 2'h2, 8'h01, 8'h01, 8'h00);
      wrap_up();
   end

   initial begin
      #400000;
      miscompares++;
      wrap_up();
   end
endmodule
